// *** dcf_deep_fifo.v ***
// Notes on behaviour
// - Master reset empties the FIFO and drives the empty flag low.
// - After master reset data outputs are low when output drive enabled.
// - Write enable low and load high stores the 18-bit input word.
// - Read enable low moves the next stored word to the output register.
// - Output enable high floats outputs; low drives the output register.
// - Writes when full and reads when empty ignored; last word held.
// - Two 16-bit offset registers, empty and full, loaded from low bits.
// - Both offsets default to 127 words.
// - Load and write enable low write empty, full, empty offsets in turn.
// - Raising load resumes normal use; next load targets next offset.
// - Load and read enable low read offsets in the same alternation.
// - Full flag low when full, blocks writes, updates on write clock.
// - Empty flag low when empty, blocks reads, updates on read clock.
// - Almost flags low when count or free space is within the offset.
// - Sync select low registers almost flags on their own side's clock.
// - Half-full low above half depth; full at the whole depth.
// - Rewind pulse sends read pointer to first location; standalone only.
// - After rewind reads replay data; flags follow relative pointers.
// - In cascade use the half-full pin carries the write chain output.
`timescale 1ns/1ps
`include "dcf_consts.vh"

module dcf_deep_fifo #(
	parameter DW    = `DCF_DATA_W,
	parameter OW    = `DCF_OFF_W,
	parameter DEPTH = `DCF_DEPTH,
	parameter AW    = `DCF_ADDR_W
) (
	input  wire          CORE_CLK_I,
	input  wire          RST_N_I,
	input  wire          MASTER_RESET_N_I,
	input  wire [DW-1:0] DIN_I,
	input  wire          WR_EN_N_I,
	input  wire          RD_EN_N_I,
	input  wire          OUTPUT_EN_N_I,
	input  wire          OFFSET_LOAD_N_I,
	input  wire          REWIND_PULSE_I,
	input  wire          SYNC_FLAG_SEL_N_I,
	input  wire          CASCADE_EN_I,
	output wire [DW-1:0] DOUT_O,
	output wire          DOUT_OE_N_O,
	output wire          EMPTY_N_O,
	output wire          FULL_N_O,
	output wire          ALMOST_EMPTY_N_O,
	output wire          ALMOST_FULL_N_O,
	output wire          HALF_FULL_N_O
);

	localparam [AW:0] DEPTH_C = DEPTH[AW:0];
	localparam [AW:0] HALF_C  = DEPTH_C >> 1;
	localparam [AW:0] ZERO_C  = {(AW+1){1'b0}};

	// Binary to Gray and back, used for both pointer crossings
	function [AW:0] bin2gray;
		input [AW:0] b;
		begin
			bin2gray = b ^ (b >> 1);
		end
	endfunction

	function [AW:0] gray2bin;
		input [AW:0] g;
		integer k;
		begin
			gray2bin[AW] = g[AW];
			for (k = AW - 1; k >= 0; k = k - 1) begin
				gray2bin[k] = gray2bin[k+1] ^ g[k];
			end
		end
	endfunction

	// Count widened to the offset width for comparisons
	function [OW-1:0] widen;
		input [AW:0] c;
		begin
			widen = {{(OW-AW-1){1'b0}}, c};
		end
	endfunction

	reg  [DW-1:0] mem_q [0:DEPTH-1];
	wire          rst_n;

	reg  [AW:0]   wptr_q;
	reg  [AW:0]   wptr_d;
	reg  [AW:0]   rptr_q;
	reg  [AW:0]   rptr_d;
	reg  [AW:0]   wgray_q;
	reg  [AW:0]   rgray_q;
	reg  [AW:0]   wgray_s1_q;
	reg  [AW:0]   wgray_s2_q;
	reg  [AW:0]   rgray_s1_q;
	reg  [AW:0]   rgray_s2_q;

	reg  [OW-1:0] empty_off_q;
	reg  [OW-1:0] full_off_q;
	reg           wr_sel_q;
	reg           rd_sel_q;

	reg  [DW-1:0] dout_q;
	reg           oe_n_q;
	reg           empty_n_q;
	reg           full_n_q;
	reg           aempty_n_q;
	reg           afull_n_q;
	reg           half_n_q;

	wire          wr_req;
	wire          off_wr;
	wire          rd_req;
	wire          off_rd;
	wire          rd_take;
	wire          rewind;
	wire          stage_rdy;
	wire          stage_vld;
	wire [DW-1:0] stage_data;
	wire          mem_wr;
	wire [AW:0]   rptr_seen_w;
	wire [AW:0]   wptr_seen_r;
	wire [AW:0]   wcount;
	wire [AW:0]   live_cnt;
	wire [AW:0]   wfree;
	wire [AW:0]   lfree;
	wire [AW:0]   flag_cnt;
	wire [AW:0]   flag_free;
	wire          last_loc;
	wire          stg_push;
	wire          stg_pop;
	wire [AW:0]   mem_used_d;
	wire [AW:0]   total_d;
	reg  [AW:0]   stg_cnt_q;
	reg  [AW:0]   stg_cnt_d;

	// Either reset input empties the FIFO
	assign rst_n = RST_N_I & MASTER_RESET_N_I;

	assign wr_req = ~WR_EN_N_I & OFFSET_LOAD_N_I;
	assign off_wr = ~WR_EN_N_I & ~OFFSET_LOAD_N_I;
	assign rd_req = ~RD_EN_N_I & OFFSET_LOAD_N_I;
	assign off_rd = ~RD_EN_N_I & ~OFFSET_LOAD_N_I;
	assign rd_take = rd_req & empty_n_q;
	assign rewind = REWIND_PULSE_I & ~CASCADE_EN_I;

	// Staging buffer absorbs the write stream ahead of the deep memory
	dcf_stage_fifo #(
		.W  (DW),
		.D  (`DCF_STAGE_DEPTH),
		.AW (`DCF_STAGE_AW)
	) u_stage (
		.clk_i       (CORE_CLK_I),
		.rst_n_i     (rst_n),
		.in_valid_i  (wr_req & full_n_q),
		.in_ready_o  (stage_rdy),
		.in_data_i   (DIN_I),
		.out_valid_o (stage_vld),
		.out_ready_i (wcount != DEPTH_C),
		.out_data_o  (stage_data)
	);

	assign mem_wr = stage_vld & (wcount != DEPTH_C);
	assign stg_push = wr_req & full_n_q & stage_rdy;
	assign stg_pop  = mem_wr;

	assign rptr_seen_w = gray2bin(rgray_s2_q);
	assign wptr_seen_r = gray2bin(wgray_s2_q);

	assign wcount   = wptr_q - rptr_seen_w;
	assign live_cnt = wptr_d - rptr_d;
	assign wfree    = DEPTH_C - total_d;
	assign lfree    = DEPTH_C - live_cnt;
	assign last_loc = (wptr_q[AW-1:0] == {AW{1'b1}});

	assign mem_used_d = wptr_d - rptr_seen_w;
	assign total_d    = mem_used_d + stg_cnt_d;

	assign flag_cnt  = SYNC_FLAG_SEL_N_I ? live_cnt : (wptr_seen_r - rptr_d);
	assign flag_free = SYNC_FLAG_SEL_N_I ? lfree : wfree;

	always @* begin
		wptr_d = wptr_q;
		if (mem_wr) begin
			wptr_d = wptr_q + 1'b1;
		end
	end

	always @* begin
		rptr_d = rptr_q;
		if (rewind) begin
			rptr_d = ZERO_C;
		end else if (rd_take) begin
			rptr_d = rptr_q + 1'b1;
		end
	end

	// Staging occupancy after this edge
	always @* begin
		stg_cnt_d = stg_cnt_q;
		if (stg_push & ~stg_pop) begin
			stg_cnt_d = stg_cnt_q + 1'b1;
		end else if (stg_pop & ~stg_push) begin
			stg_cnt_d = stg_cnt_q - 1'b1;
		end
	end

	// Mirrors the staging buffer so full never admits an extra word
	always @(posedge CORE_CLK_I) begin
		if (!rst_n) begin
			stg_cnt_q <= ZERO_C;
		end else begin
			stg_cnt_q <= stg_cnt_d;
		end
	end

	always @(posedge CORE_CLK_I) begin
		if (mem_wr) begin
			mem_q[wptr_q[AW-1:0]] <= stage_data;
		end
	end

	// Pointer state and Gray crossing
	always @(posedge CORE_CLK_I) begin
		if (!rst_n) begin
			wptr_q     <= ZERO_C;
			rptr_q     <= ZERO_C;
			wgray_q    <= ZERO_C;
			rgray_q    <= ZERO_C;
			wgray_s1_q <= ZERO_C;
			wgray_s2_q <= ZERO_C;
			rgray_s1_q <= ZERO_C;
			rgray_s2_q <= ZERO_C;
		end else begin
			wptr_q     <= wptr_d;
			rptr_q     <= rptr_d;
			wgray_q    <= bin2gray(wptr_d);
			rgray_q    <= bin2gray(rptr_d);
			wgray_s1_q <= wgray_q;
			wgray_s2_q <= wgray_s1_q;
			rgray_s1_q <= rgray_q;
			rgray_s2_q <= rgray_s1_q;
		end
	end

	// Offset registers and their separate write and read alternations
	always @(posedge CORE_CLK_I) begin
		if (!rst_n) begin
			empty_off_q <= `DCF_OFF_RESET;
			full_off_q  <= `DCF_OFF_RESET;
			wr_sel_q    <= `DCF_SEL_EMPTY;
			rd_sel_q    <= `DCF_SEL_EMPTY;
		end else begin
			if (off_wr) begin
				if (wr_sel_q == `DCF_SEL_EMPTY) begin
					empty_off_q <= DIN_I[OW-1:0];
				end else begin
					full_off_q <= DIN_I[OW-1:0];
				end
				wr_sel_q <= ~wr_sel_q;
			end
			if (off_rd) begin
				rd_sel_q <= ~rd_sel_q;
			end
		end
	end

	// Output register and drive enable
	always @(posedge CORE_CLK_I) begin
		if (!rst_n) begin
			dout_q <= {DW{1'b0}};
			oe_n_q <= 1'b1;
		end else begin
			oe_n_q <= OUTPUT_EN_N_I;
			if (off_rd) begin
				if (rd_sel_q == `DCF_SEL_EMPTY) begin
					dout_q <= {{(DW-OW){1'b0}}, empty_off_q};
				end else begin
					dout_q <= {{(DW-OW){1'b0}}, full_off_q};
				end
			end else if (rd_take & ~rewind) begin
				dout_q <= mem_q[rptr_q[AW-1:0]];
			end
		end
	end

	// Status flags
	always @(posedge CORE_CLK_I) begin
		if (!rst_n) begin
			empty_n_q  <= 1'b0;
			full_n_q   <= 1'b1;
			aempty_n_q <= 1'b0;
			afull_n_q  <= 1'b1;
			half_n_q   <= 1'b1;
		end else begin
			empty_n_q <= ((wptr_seen_r - rptr_d) != ZERO_C);
			full_n_q  <= (total_d < DEPTH_C) & stage_rdy;
			aempty_n_q <= (widen(flag_cnt) > empty_off_q);
			afull_n_q  <= (widen(flag_free) > full_off_q);
			if (CASCADE_EN_I) begin
				half_n_q <= ~(mem_wr & last_loc);
			end else begin
				half_n_q <= (total_d <= HALF_C);
			end
		end
	end

	assign DOUT_O           = dout_q;
	assign DOUT_OE_N_O      = oe_n_q;
	assign EMPTY_N_O        = empty_n_q;
	assign FULL_N_O         = full_n_q;
	assign ALMOST_EMPTY_N_O = aempty_n_q;
	assign ALMOST_FULL_N_O  = afull_n_q;
	assign HALF_FULL_N_O    = half_n_q;

endmodule // dcf_deep_fifo

// *** dcf_consts.vh ***
`ifndef DCF_CONSTS_VH
`define DCF_CONSTS_VH

// Data path and offset register widths
`define DCF_DATA_W      18
`define DCF_OFF_W       16

// Deep memory: 8K words, 13 address bits
`define DCF_DEPTH       8192
`define DCF_ADDR_W      13

// Offset register reset value, 127 words
`define DCF_OFF_RESET   16'h007f

// Staging buffer in front of the deep memory
`define DCF_STAGE_DEPTH 8
`define DCF_STAGE_AW    3

// Offset sequence selector values
`define DCF_SEL_EMPTY   1'b0
`define DCF_SEL_FULL    1'b1

`endif

// *** dcf_stage_fifo.v ***
`timescale 1ns/1ps
`include "dcf_consts.vh"

module dcf_stage_fifo #(
	parameter W  = `DCF_DATA_W,
	parameter D  = `DCF_STAGE_DEPTH,
	parameter AW = `DCF_STAGE_AW
) (
	input  wire          clk_i,
	input  wire          rst_n_i,
	input  wire          in_valid_i,
	output wire          in_ready_o,
	input  wire [W-1:0]  in_data_i,
	output wire          out_valid_o,
	input  wire          out_ready_i,
	output wire [W-1:0]  out_data_o
);

	reg  [W-1:0] mem_q [0:D-1];
	reg  [AW-1:0] wr_q;
	reg  [AW-1:0] rd_q;
	reg  [AW:0]   cnt_q;
	wire          push;
	wire          pop;
	localparam [AW:0] FULL_CNT = D[AW:0];

	assign in_ready_o  = (cnt_q != FULL_CNT);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o  = mem_q[rd_q];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (push & ~pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop & ~push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

endmodule // dcf_stage_fifo

// *** dcf_deep_fifo_sva.sv ***
`timescale 1ns/1ps
module dcf_deep_fifo_sva #(
	parameter DW = 18
) (
	input wire          CORE_CLK_I,
	input wire          RST_N_I,
	input wire          MASTER_RESET_N_I,
	input wire          WR_EN_N_I,
	input wire          RD_EN_N_I,
	input wire          OUTPUT_EN_N_I,
	input wire          OFFSET_LOAD_N_I,
	input wire          REWIND_PULSE_I,
	input wire [DW-1:0] DOUT_O,
	input wire          DOUT_OE_N_O,
	input wire          EMPTY_N_O,
	input wire          FULL_N_O,
	input wire          HALF_FULL_N_O
);
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	a_mr_empties: assert property (!MASTER_RESET_N_I |=>
		!EMPTY_N_O && FULL_N_O && DOUT_O == '0)
		else $error("master reset left data or flags");
	a_rd_idle_hold: assert property (
		RD_EN_N_I && MASTER_RESET_N_I |=> $stable(DOUT_O))
		else $error("output changed without a read");
	a_empty_no_rd: assert property (
		!EMPTY_N_O && OFFSET_LOAD_N_I && MASTER_RESET_N_I |=> $stable(DOUT_O))
		else $error("read taken while empty");
	a_oe_copy: assert property (MASTER_RESET_N_I && RST_N_I |=>
		DOUT_OE_N_O == $past(OUTPUT_EN_N_I))
		else $error("drive enable not followed");
	a_full_holds: assert property (
		(RD_EN_N_I && MASTER_RESET_N_I)[*6] ##0 !FULL_N_O |=> !FULL_N_O)
		else $error("full cleared without a read");
	a_empty_holds: assert property (
		(WR_EN_N_I && !REWIND_PULSE_I && MASTER_RESET_N_I)[*8]
		##0 !EMPTY_N_O |=> !EMPTY_N_O)
		else $error("empty cleared without a write");
	a_wr_fills: assert property (
		(!WR_EN_N_I && OFFSET_LOAD_N_I && FULL_N_O && MASTER_RESET_N_I)
		##1 (RD_EN_N_I && MASTER_RESET_N_I)[*7] |-> EMPTY_N_O)
		else $error("write not stored");
	a_offset_rd: assert property (
		!RD_EN_N_I && !OFFSET_LOAD_N_I && MASTER_RESET_N_I
		|=> DOUT_O[DW-1:16] == '0)
		else $error("offset read upper bits set");

	c_offset_rd: cover property (!RD_EN_N_I && !OFFSET_LOAD_N_I);
	c_full: cover property (!FULL_N_O);
	c_half: cover property (!HALF_FULL_N_O);
endmodule // dcf_deep_fifo_sva

// *** dcf_far_end.sv ***
`timescale 1ns/1ps
module dcf_far_end (
	input  wire        clk_i,
	input  wire        empty_n_i,
	output reg  [17:0] din_o,
	output reg         wr_en_n_o,
	output reg         rd_en_n_o,
	output reg         load_n_o
);
	initial begin
		din_o = 18'h15555;
		wr_en_n_o = 1'b1;
		rd_en_n_o = 1'b1;
		load_n_o = 1'b1;
	end

	task burst(input int n, input logic [17:0] base, input logic ld);
		@(posedge clk_i);
		wr_en_n_o <= 1'b0;
		load_n_o <= ld;
		for (int i = 0; i < n; i++) begin
			din_o <= base + 18'(i);
			@(posedge clk_i);
		end
		wr_en_n_o <= 1'b1;
		load_n_o <= 1'b1;
		din_o <= ~din_o;
	endtask

	task rd(input logic ld);
		for (int k = 0; k < 20 && ld && !empty_n_i; k++) begin
			@(posedge clk_i);
			#1;
		end
		@(posedge clk_i);
		rd_en_n_o <= 1'b0;
		load_n_o <= ld;
		@(posedge clk_i);
		rd_en_n_o <= 1'b1;
		load_n_o <= 1'b1;
		#1;
	endtask
endmodule // dcf_far_end

// *** dcf_deep_fifo_tb.sv ***
`timescale 1ns/1ps
module dcf_deep_fifo_tb;
	reg         clk;
	reg         rst_n;
	reg         mr_n;
	reg         oe_n;
	reg         rw;
	reg         sfs_n;
	reg         casc;
	wire [17:0] din;
	wire [17:0] dout;
	wire [17:0] bus;
	wire        wr_n, rd_n, ld_n, oe_q, e_n, f_n, ae_n, af_n, hf_n;
	int         err_total;
	int         n_compared;

	assign bus = oe_q ? {18{1'bz}} : dout;

	dcf_far_end u_dcf_far_end (.clk_i(clk), .empty_n_i(e_n), .din_o(din),
		.wr_en_n_o(wr_n), .rd_en_n_o(rd_n), .load_n_o(ld_n));
	dcf_deep_fifo u_dcf_deep_fifo (.CORE_CLK_I(clk), .RST_N_I(rst_n),
		.MASTER_RESET_N_I(mr_n), .DIN_I(din), .WR_EN_N_I(wr_n),
		.RD_EN_N_I(rd_n), .OUTPUT_EN_N_I(oe_n), .OFFSET_LOAD_N_I(ld_n),
		.REWIND_PULSE_I(rw), .SYNC_FLAG_SEL_N_I(sfs_n), .CASCADE_EN_I(casc),
		.DOUT_O(dout), .DOUT_OE_N_O(oe_q), .EMPTY_N_O(e_n), .FULL_N_O(f_n),
		.ALMOST_EMPTY_N_O(ae_n), .ALMOST_FULL_N_O(af_n),
		.HALF_FULL_N_O(hf_n));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task chk(input string nm, input logic [17:0] e, input logic [17:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task settle;
		repeat (10) @(posedge clk);
		#1;
	endtask

	task summarize;
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task t_reset;
		@(posedge clk);
		mr_n <= 1'b0;
		repeat (2) @(posedge clk);
		mr_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("empty", 18'h0, e_n);
		chk("dout", 18'h0, bus);
		chk("ae", 18'h0, ae_n);
	endtask

	task t_order;
		u_dcf_far_end.burst(3, 18'h2a001, 1'b1);
		for (int i = 1; i < 4; i++) begin
			u_dcf_far_end.rd(1'b1);
			chk("word", 18'h2a000 + 18'(i), bus);
		end
		u_dcf_far_end.rd(1'b1);
		chk("hold", 18'h2a003, bus);
		@(posedge clk);
		rw <= 1'b1;
		@(posedge clk);
		rw <= 1'b0;
		for (int i = 1; i < 4; i++) begin
			u_dcf_far_end.rd(1'b1);
			chk("replay", 18'h2a000 + 18'(i), bus);
		end
	endtask

	task t_oe;
		@(posedge clk);
		oe_n <= 1'b1;
		settle;
		chk("float", {18{1'bz}}, bus);
		@(posedge clk);
		oe_n <= 1'b0;
		settle;
		chk("drive", 18'h2a003, bus);
	endtask

	task t_offset;
		u_dcf_far_end.burst(2, 18'h5, 1'b0);
		u_dcf_far_end.rd(1'b0);
		chk("eoff", 18'h5, bus);
		u_dcf_far_end.rd(1'b0);
		chk("foff", 18'h6, bus);
		u_dcf_far_end.burst(6, 18'h1, 1'b1);
		settle;
		chk("ae6", 18'h1, ae_n);
		u_dcf_far_end.rd(1'b1);
		settle;
		chk("ae5", 18'h0, ae_n);
		@(posedge clk);
		sfs_n <= 1'b1;
		u_dcf_far_end.burst(1, 18'h7, 1'b1);
		@(posedge clk);
		#1;
		chk("ae_live", 18'h1, ae_n);
		@(posedge clk);
		sfs_n <= 1'b0;
	endtask

	task t_fill;
		u_dcf_far_end.burst(127, 18'h100, 1'b1);
		settle;
		chk("ae127", 18'h0, ae_n);
		u_dcf_far_end.burst(1, 18'h1, 1'b1);
		settle;
		chk("ae128", 18'h1, ae_n);
		u_dcf_far_end.burst(3968, 18'h2, 1'b1);
		settle;
		chk("hf4096", 18'h1, hf_n);
		u_dcf_far_end.burst(1, 18'h3, 1'b1);
		settle;
		chk("hf4097", 18'h0, hf_n);
		@(posedge clk);
		casc <= 1'b1;
		settle;
		chk("hfcasc", 18'h1, hf_n);
		@(posedge clk);
		casc <= 1'b0;
		u_dcf_far_end.burst(4094, 18'h4, 1'b1);
		settle;
		chk("nf8191", 18'h1, f_n);
		u_dcf_far_end.burst(1, 18'h5, 1'b1);
		settle;
		chk("full", 18'h0, f_n);
		chk("af", 18'h0, af_n);
		u_dcf_far_end.burst(4, 18'h6, 1'b1);
		settle;
		u_dcf_far_end.rd(1'b1);
		chk("first", 18'h100, bus);
	endtask

	initial begin
		rst_n = 1'b0;
		mr_n = 1'b1;
		oe_n = 1'b0;
		rw = 1'b0;
		sfs_n = 1'b0;
		casc = 1'b0;
		err_total = 0;
		n_compared = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_order;
		t_oe;
		t_offset;
		t_reset;
		t_fill;
		t_reset;
		summarize;
	end

	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		summarize;
	end
endmodule // dcf_deep_fifo_tb

bind dcf_deep_fifo dcf_deep_fifo_sva #(.DW(DW)) u_sva (.CORE_CLK_I,
	.RST_N_I, .MASTER_RESET_N_I, .WR_EN_N_I, .RD_EN_N_I, .OUTPUT_EN_N_I,
	.OFFSET_LOAD_N_I, .REWIND_PULSE_I, .DOUT_O, .DOUT_OE_N_O, .EMPTY_N_O,
	.FULL_N_O, .HALF_FULL_N_O);
